//--- chan_regs_pkg.sv
// Package: command decode, field layout and reset values of the channel mode registers
package chan_regs_pkg;
  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam logic [6:0]  ADDR_MODE      = 7'h05;
  localparam logic [6:0]  ADDR_GAIN      = 7'h06;
  localparam logic [6:0]  ADDR_ROUTE     = 7'h07;
  localparam logic [6:0]  ADDR_SHIFT     = 7'h08;
  localparam int          DIR_BIT        = 7;
  localparam logic [7:0]  MODE_RESET     = 8'h80;
  localparam logic [7:0]  GAIN_RESET     = 8'h00;
  localparam logic [7:0]  ROUTE_RESET    = 8'h00;
  localparam logic [7:0]  SHIFT_RESET    = 8'h00;
  localparam logic [7:0]  GAIN_WMASK     = 8'h7f;
  localparam logic [7:0]  ROUTE_WMASK    = 8'hbf;
  localparam logic [3:0]  SHIFT_MAX      = 4'ha;
  localparam logic [3:0]  SHIFT_SAT      = 4'hb;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  typedef enum logic [2:0] {
    LI_NORMAL_ACTIVE, LI_EXT_RING, LI_INT_RING, LI_RING_OPEN,
    LI_TIP_OPEN, LI_INT_TEST, LI_LOW_POWER_STBY, LI_POWER_DOWN
  } line_mode_t;

  typedef struct packed {
    logic       power_down;
    logic       standby;
    logic       active;
    logic       ramp;
    logic       line_access;
    line_mode_t line_iface_mode_field;
  } mode_reg_t;

  typedef struct packed {
    logic reserved;
    logic da_gain_select;
    logic impedance_scaling_bit;
    logic ring_mode;
    logic ring_trip_type_bit;
    logic ring_gen_enable;
    logic tone_gen_two_enable;
    logic tone_gen_one_enable;
  } gain_reg_t;

  typedef struct packed {
    logic ramp_gen_enable;
    logic reserved;
    logic meter_filter_shape_bit;
    logic meter_filter_enable;
    logic meter_ac_dc_select;
    logic meter_dc_direction_select;
    logic tone_detector_source_bit;
    logic tone_detector_enable;
  } route_reg_t;

  typedef struct packed {
    logic [3:0] shift_code;
    logic [3:0] meter_input_field;
  } shift_reg_t;

  typedef struct packed {
    logic       power_down;
    logic       standby;
    logic       active;
    logic       ramp;
    logic       ring_mode;
  } codec_mode_t;

  typedef struct packed {
    logic       line_access;
    line_mode_t mode;
  } line_ctl_t;

  // Serial control command: dir=1 reads, low seven bits address
  typedef struct packed {
    logic             valid;
    logic [7:0]       cmd;
    logic [7:0]       wdata;
  } cmd_t;
endpackage

//--- meter_shift_decode.sv
// Level meter shift code saturation into a right-shift amount
`timescale 1ns/1ps
module meter_shift_decode (
  input  wire logic [3:0] shift_code,  // Register code
  output logic      [3:0] shift_amount // Effective shift, 0..11
);
  import chan_regs_pkg::*;
  // Codes beyond ten all clamp to the deepest shift
  always_comb begin
    if (shift_code > SHIFT_MAX) begin
      shift_amount = SHIFT_SAT;
    end else begin
      shift_amount = shift_code;
    end
  end
endmodule

//--- channel_mode_and_meter_control_regs.sv
// Per-channel mode, gain, generator and meter routing register bank
`timescale 1ns/1ps
module channel_mode_and_meter_control_regs
(
  input  wire logic                          clk,                // 200 MHz device clock
  input  wire logic                          resetn,             // Sync reset, active low
  input  wire chan_regs_pkg::cmd_t           cmd_in,             // Command byte and write data
  input  wire logic                          serial_port_mode,   // 1: serial circuit port mode
  input  wire chan_regs_pkg::line_ctl_t      downstream_line,    // Line bits from downstream byte
  output logic                               rd_valid,           // Read data valid, one cycle
  output logic                         [7:0] rd_data,            // Read data byte
  output chan_regs_pkg::codec_mode_t         codec_mode,         // Codec operating mode
  output chan_regs_pkg::line_ctl_t           line_ctl,           // Line interface control
  output chan_regs_pkg::gain_reg_t           gain_ctl,           // Gain and generator enables
  output chan_regs_pkg::route_reg_t          route_ctl,          // Meter and detector routing
  output logic                         [3:0] meter_shift,        // Effective meter shift
  output logic                         [3:0] meter_input_field   // Meter input select
);
  import chan_regs_pkg::*;

  typedef struct packed {
    mode_reg_t  mode;
    gain_reg_t  gain;
    route_reg_t route;
    shift_reg_t shift;
    line_ctl_t  line;
    logic       rd_valid;
    logic [7:0] rd_data;
  } state_t;

  state_t st;
  state_t next_st;

  logic       is_read;
  logic [6:0] addr;
  logic [3:0] shift_amount;

  assign is_read = cmd_in.cmd[DIR_BIT];
  assign addr    = cmd_in.cmd[ADDR_W-1:0];

  function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
    hit = (a == target);
  endfunction

  // A seven-bit address under one direction bit is all the decode handles
  if (ADDR_W + 1 != DATA_W || DIR_BIT != ADDR_W) begin : g_layout_check
    $error("Command byte must be address plus direction bit");
  end

  always_comb begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    if (cmd_in.valid && !is_read) begin
      if (hit(addr, ADDR_MODE)) begin
        next_st.mode = mode_reg_t'(cmd_in.wdata);
      end else if (hit(addr, ADDR_GAIN)) begin
        next_st.gain = gain_reg_t'(cmd_in.wdata & GAIN_WMASK);
      end else if (hit(addr, ADDR_ROUTE)) begin
        next_st.route = route_reg_t'(cmd_in.wdata & ROUTE_WMASK);
      end else if (hit(addr, ADDR_SHIFT)) begin
        next_st.shift = shift_reg_t'(cmd_in.wdata);
      end
    end
    if (cmd_in.valid && is_read) begin
      next_st.rd_valid = 1'b1;
      if (hit(addr, ADDR_MODE)) begin
        next_st.rd_data = st.mode;
      end else if (hit(addr, ADDR_GAIN)) begin
        next_st.rd_data = st.gain;
      end else if (hit(addr, ADDR_ROUTE)) begin
        next_st.rd_data = st.route;
      end else if (hit(addr, ADDR_SHIFT)) begin
        next_st.rd_data = st.shift;
      end else begin
        next_st.rd_data = ZERO_BYTE;
      end
    end
    // Registered select so a port-mode change never glitches the line drive
    if (serial_port_mode) begin
      next_st.line = downstream_line;
    end else begin
      next_st.line = '{line_access: st.mode.line_access,
                       mode: st.mode.line_iface_mode_field};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st.mode     <= mode_reg_t'(MODE_RESET);
      st.gain     <= gain_reg_t'(GAIN_RESET);
      st.route    <= route_reg_t'(ROUTE_RESET);
      st.shift    <= shift_reg_t'(SHIFT_RESET);
      st.line     <= '{line_access: 1'b0, mode: LI_NORMAL_ACTIVE};
      st.rd_valid <= 1'b0;
      st.rd_data  <= ZERO_BYTE;
    end else begin
      st <= next_st;
    end
  end

  meter_shift_decode u_shift (
    .shift_code   (st.shift.shift_code),
    .shift_amount (shift_amount)
  );

  assign rd_valid          = st.rd_valid;
  assign rd_data           = st.rd_data;
  assign codec_mode        = '{power_down: st.mode.power_down, standby: st.mode.standby,
                               active: st.mode.active, ramp: st.mode.ramp,
                               ring_mode: st.gain.ring_mode};
  assign line_ctl          = st.line;
  assign gain_ctl          = st.gain;
  assign route_ctl         = st.route;
  assign meter_shift       = shift_amount;
  assign meter_input_field = st.shift.meter_input_field;

  // Write byte seen through the mode, gain and routing register layouts, read only by the checks below
  mode_reg_t  wr_mode;
  gain_reg_t  wr_gain;
  route_reg_t wr_route;

  assign wr_mode  = mode_reg_t'(cmd_in.wdata);
  assign wr_gain  = gain_reg_t'(cmd_in.wdata);
  assign wr_route = route_reg_t'(cmd_in.wdata);

  sequence s_write(logic [6:0] a);
    cmd_in.valid && !is_read && addr == a;
  endsequence

  sequence s_read(logic [6:0] a);
    cmd_in.valid && is_read && addr == a;
  endsequence

  sequence s_unmapped_write;
    cmd_in.valid && !is_read && (addr < ADDR_MODE || addr > ADDR_SHIFT);
  endsequence

  // Processor-port line drive trails the register by one more cycle
  sequence s_mode_then_proc;
    s_write(ADDR_MODE) ##1 !serial_port_mode;
  endsequence

  chk_reset_powerdown: assert property (@(posedge clk)
    !resetn |=> codec_mode.power_down && !codec_mode.standby)
    else $error("Power-down not set after reset");

  chk_mode_write_read: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_MODE) ##1 s_read(ADDR_MODE) |=> rd_valid && rd_data == $past(cmd_in.wdata, 2))
    else $error("Mode register readback mismatch");

  chk_gain_reserved: assert property (@(posedge clk) disable iff (!resetn)
    s_read(ADDR_GAIN) |=> rd_valid && !rd_data[7])
    else $error("Reserved gain bit read nonzero");

  chk_route_reserved: assert property (@(posedge clk) disable iff (!resetn)
    s_read(ADDR_ROUTE) |=> rd_data[6] == 1'b0)
    else $error("Reserved routing bit read nonzero");

  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
    cmd_in.valid && is_read && addr > ADDR_SHIFT |=> rd_valid && rd_data == ZERO_BYTE)
    else $error("Unmapped read not zero");

  chk_ring_follow: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_GAIN) |=> codec_mode.ring_mode == $past(cmd_in.wdata[4]))
    else $error("Ring mode does not follow bit four");

  chk_line_serial: assert property (@(posedge clk) disable iff (!resetn)
    serial_port_mode ##1 serial_port_mode |-> line_ctl == $past(downstream_line))
    else $error("Serial port line mode not taken from downstream byte");

  chk_line_proc: assert property (@(posedge clk) disable iff (!resetn)
    !serial_port_mode[*2] |-> line_ctl.mode == $past(st.mode.line_iface_mode_field))
    else $error("Processor port line mode not from register");

  chk_shift_sat: assert property (@(posedge clk) disable iff (!resetn)
    st.shift.shift_code > SHIFT_MAX |-> meter_shift == SHIFT_SAT)
    else $error("Shift code did not saturate");

  chk_route_write: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_ROUTE) |=> route_ctl.ramp_gen_enable == $past(cmd_in.wdata[7]))
    else $error("Ramp enable not written");

  chk_reset_codec_off: assert property (@(posedge clk)
    !resetn |=> !codec_mode.standby && !codec_mode.active && !codec_mode.ramp)
    else $error("Codec enables not off after reset");

  chk_reset_line_access: assert property (@(posedge clk)
    !resetn |=> !st.mode.line_access && !line_ctl.line_access)
    else $error("Line access not clear after reset");

  chk_reset_line_mode: assert property (@(posedge clk)
    !resetn |=> st.mode.line_iface_mode_field == LI_NORMAL_ACTIVE)
    else $error("Line mode not normal active after reset");

  chk_reset_scaling: assert property (@(posedge clk)
    !resetn |=> !gain_ctl.impedance_scaling_bit)
    else $error("Impedance scaling not 600 after reset");

  chk_reset_ring_mode: assert property (@(posedge clk)
    !resetn |=> !codec_mode.ring_mode)
    else $error("Ring mode not off after reset");

  chk_reset_trip_ac: assert property (@(posedge clk)
    !resetn |=> !gain_ctl.ring_trip_type_bit)
    else $error("Ring trip not AC after reset");

  chk_reset_ring_gen: assert property (@(posedge clk)
    !resetn |=> !gain_ctl.ring_gen_enable)
    else $error("Ring generator not stopped after reset");

  chk_reset_tone_gens: assert property (@(posedge clk)
    !resetn |=> !gain_ctl.tone_gen_two_enable && !gain_ctl.tone_gen_one_enable)
    else $error("Tone generators not off after reset");

  chk_reset_ramp_gen: assert property (@(posedge clk)
    !resetn |=> !route_ctl.ramp_gen_enable)
    else $error("Ramp generator not off after reset");

  chk_reset_notch: assert property (@(posedge clk)
    !resetn |=> !route_ctl.meter_filter_shape_bit)
    else $error("Meter filter not notch after reset");

  chk_reset_filter_out: assert property (@(posedge clk)
    !resetn |=> !route_ctl.meter_filter_enable)
    else $error("Meter filter not bypassed after reset");

  chk_reset_meter_dc: assert property (@(posedge clk)
    !resetn |=> !route_ctl.meter_ac_dc_select)
    else $error("Meter source not DC after reset");

  chk_reset_dc_receive: assert property (@(posedge clk)
    !resetn |=> !route_ctl.meter_dc_direction_select)
    else $error("Meter DC path not receive after reset");

  chk_reset_detect_rx: assert property (@(posedge clk)
    !resetn |=> !route_ctl.tone_detector_source_bit)
    else $error("Tone detector source not receive after reset");

  chk_reset_detect_off: assert property (@(posedge clk)
    !resetn |=> !route_ctl.tone_detector_enable)
    else $error("Tone detector not off after reset");

  chk_reset_shift_unity: assert property (@(posedge clk)
    !resetn |=> meter_shift == '0)
    else $error("Meter shift not unity after reset");

  chk_mode_write: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_MODE) |=> st.mode == $past(wr_mode))
    else $error("Mode register write did not land");

  chk_powerdown_exit: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_MODE) ##0 !wr_mode.power_down |=> !codec_mode.power_down)
    else $error("Power-down not left on zero write");

  chk_codec_enables: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_MODE) |=> codec_mode.standby == $past(wr_mode.standby) &&
    codec_mode.active == $past(wr_mode.active) && codec_mode.ramp == $past(wr_mode.ramp))
    else $error("Codec mode enables not written");

  chk_ring_untouched: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_MODE) |=> $stable(codec_mode.ring_mode))
    else $error("Mode write disturbed ring mode");

  chk_line_access_set: assert property (@(posedge clk) disable iff (!resetn)
    s_mode_then_proc |=> line_ctl.line_access == $past(wr_mode.line_access, 2))
    else $error("Line access not driven from register");

  chk_line_mode_code: assert property (@(posedge clk) disable iff (!resetn)
    s_mode_then_proc |=> line_ctl.mode == $past(wr_mode.line_iface_mode_field, 2))
    else $error("Line mode code not driven from register");

  chk_gain_write: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_GAIN) |=> gain_ctl == ($past(cmd_in.wdata) & GAIN_WMASK))
    else $error("Gain register write did not land");

  chk_scaling_select: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_GAIN) |=>
    gain_ctl.impedance_scaling_bit == $past(wr_gain.impedance_scaling_bit))
    else $error("Impedance scaling not written");

  chk_trip_select: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_GAIN) |=>
    gain_ctl.ring_trip_type_bit == $past(wr_gain.ring_trip_type_bit))
    else $error("Ring trip type not written");

  chk_ring_gen_follow: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_GAIN) |=>
    gain_ctl.ring_gen_enable == $past(wr_gain.ring_gen_enable))
    else $error("Ring generator enable not written");

  chk_tone_gen_follow: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_GAIN) |=>
    gain_ctl.tone_gen_two_enable == $past(wr_gain.tone_gen_two_enable) &&
    gain_ctl.tone_gen_one_enable == $past(wr_gain.tone_gen_one_enable))
    else $error("Tone generator enables not written");

  chk_meter_filter: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_ROUTE) |=>
    route_ctl.meter_filter_shape_bit == $past(wr_route.meter_filter_shape_bit))
    else $error("Meter filter shape not written");

  chk_filter_insert: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_ROUTE) |=>
    route_ctl.meter_filter_enable == $past(wr_route.meter_filter_enable))
    else $error("Meter filter enable not written");

  chk_meter_source: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_ROUTE) |=>
    route_ctl.meter_ac_dc_select == $past(wr_route.meter_ac_dc_select))
    else $error("Meter source not written");

  chk_dc_direction: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_ROUTE) |=>
    route_ctl.meter_dc_direction_select == $past(wr_route.meter_dc_direction_select))
    else $error("Meter DC direction not written");

  chk_detect_source: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_ROUTE) |=>
    route_ctl.tone_detector_source_bit == $past(wr_route.tone_detector_source_bit))
    else $error("Tone detector source not written");

  chk_detect_enable: assert property (@(posedge clk) disable iff (!resetn)
    s_write(ADDR_ROUTE) |=>
    route_ctl.tone_detector_enable == $past(wr_route.tone_detector_enable))
    else $error("Tone detector enable not written");

  chk_shift_pass: assert property (@(posedge clk) disable iff (!resetn)
    st.shift.shift_code <= SHIFT_MAX |-> meter_shift == st.shift.shift_code)
    else $error("Shift code below saturation altered");

  chk_unmapped_write: assert property (@(posedge clk) disable iff (!resetn)
    s_unmapped_write |=> $stable(st.mode) && $stable(st.gain) && $stable(st.route))
    else $error("Unmapped write changed a register");

  chk_rd_only_after_read: assert property (@(posedge clk) disable iff (!resetn)
    !(cmd_in.valid && is_read) |=> !rd_valid)
    else $error("Read valid without a read command");
endmodule

//--- host_port_model.sv
// Host model: issues command bytes to the channel register bank
`timescale 1ns/1ps
module host_port_model (
  input  wire logic          clk,   // Device clock
  output chan_regs_pkg::cmd_t cmd_o // Command toward the bank
);
  import chan_regs_pkg::*;
  initial cmd_o = '{valid: 1'b0, cmd: 8'h00, wdata: 8'h00};
  // Held from a falling edge across the taking edge; back to back allowed
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk);
    cmd_o = '{valid: 1'b1, cmd: c, wdata: d};
  endtask
  // Released lines flip so a stale byte is never mistaken for a command
  task automatic idle();
    @(negedge clk);
    cmd_o = '{valid: 1'b0, cmd: ~cmd_o.cmd, wdata: ~cmd_o.wdata};
  endtask
endmodule

//--- test_channel_mode_and_meter_control_regs.sv
// Self-checking bench for the channel mode and meter register bank
`timescale 1ns/1ps
module test_channel_mode_and_meter_control_regs;
  import chan_regs_pkg::*;
  logic        clk, resetn, serial_port_mode, rd_valid;
  logic [7:0]  rd_data;
  logic [3:0]  meter_shift, meter_input_field;
  cmd_t        cmd_in;
  line_ctl_t   downstream_line, line_ctl;
  codec_mode_t codec_mode;
  gain_reg_t   gain_ctl;
  route_reg_t  route_ctl;
  int          n_mismatch, compares;
  logic [7:0]  exp_q[$];
  logic [7:0]  shadow [5:8];
  logic [7:0]  wmask [5:8];
  logic [7:0]  unmapped [4];

  host_port_model host_port_model_i (.clk(clk), .cmd_o(cmd_in));
  channel_mode_and_meter_control_regs channel_mode_and_meter_control_regs_i (
    .clk(clk), .resetn(resetn), .cmd_in(cmd_in), .serial_port_mode(serial_port_mode),
    .downstream_line(downstream_line), .rd_valid(rd_valid), .rd_data(rd_data),
    .codec_mode(codec_mode), .line_ctl(line_ctl), .gain_ctl(gain_ctl),
    .route_ctl(route_ctl), .meter_shift(meter_shift), .meter_input_field(meter_input_field));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Read results are matched in order against the notes left by rd
  always @(negedge clk) begin
    if (rd_valid === 1'b1 && exp_q.size() == 0) begin
      check({7'h0, rd_valid}, 8'h00);
    end else if (rd_valid === 1'b1) begin
      check(rd_data, exp_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_port_model_i.send(a, d);
    if (a >= 8'h05 && a <= 8'h08) shadow[a] = d & wmask[a];
  endtask

  task automatic rd(input logic [7:0] a);
    host_port_model_i.send(a | 8'h80, 8'($urandom));
    exp_q.push_back((a >= 8'h05 && a <= 8'h08) ? shadow[a] : 8'h00);
  endtask

  task automatic check_outs();
    host_port_model_i.idle();
    repeat (2) @(negedge clk);
    check({3'h0, codec_mode}, {3'h0, shadow[5][7:4], shadow[6][4]});
    check(gain_ctl, shadow[6]);
    check(route_ctl, shadow[7]);
    check({4'h0, meter_input_field}, {4'h0, shadow[8][3:0]});
    check({4'h0, meter_shift}, {4'h0, (shadow[8][7:4] > 4'ha) ? 4'hb : shadow[8][7:4]});
    check({4'h0, line_ctl}, {4'h0, serial_port_mode ? downstream_line : shadow[5][3:0]});
  endtask

  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    wmask = '{8'hff, 8'h7f, 8'hbf, 8'hff};
    shadow = '{8'h80, 8'h00, 8'h00, 8'h00};
    unmapped = '{8'h00, 8'h04, 8'h09, 8'h7f};
    resetn = 1'b0;
    serial_port_mode = 1'b0;
    downstream_line = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    void'($urandom(32'h4f7e));
    for (int a = 5; a <= 8; a++) rd(8'(a));
    check_outs();
    $display("test reset_values done");
    for (int i = 0; i < 40; i++) begin
      logic [7:0] a;
      a = 8'(5 + $urandom_range(3));
      wr(a, 8'($urandom));
      rd(a);
      check_outs();
    end
    $display("test random_write_read done");
    for (int m = 0; m < 16; m++) begin
      wr(8'h05, {4'($urandom), 1'b1, 3'(m)});
      wr(8'h08, {4'(m), 4'($urandom)});
      rd(8'h05);
      check_outs();
    end
    $display("test mode_and_shift_codes done");
    foreach (unmapped[k]) begin
      wr(unmapped[k], 8'hff);
      rd(unmapped[k]);
    end
    for (int a = 5; a <= 8; a++) rd(8'(a));
    check_outs();
    $display("test unmapped_access done");
    serial_port_mode = 1'b1;
    for (int i = 0; i < 8; i++) begin
      downstream_line = 4'($urandom);
      wr(8'h05, 8'($urandom));
      check_outs();
    end
    $display("test serial_port_mode done");
    repeat (4) @(negedge clk);
    check(8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule
